// ---- design/tmr_pkg.sv ----
// constants, register map and types for the 8-bit timer with shared prescaler
// assumes a 32-bit apb master and a 10 mhz system clock used as the oscillator clock
package tmr_pkg;

	// register byte offsets on the apb
	localparam logic [11:0] ADDR_COUNT  = 12'h000; // timer_count
	localparam logic [11:0] ADDR_INTCTL = 12'h004; // interrupt_control
	localparam logic [11:0] ADDR_CONFIG = 12'h008; // timer_and_pin_config
	localparam logic [11:0] ADDR_PORT_A_DIRECTION  = 12'h00C; // port_a_direction
	localparam logic [11:0] ADDR_STATUS = 12'h010; // sticky event status, write one to clear
	localparam logic [11:0] ADDR_MASK   = 12'h014; // interrupt mask

	// reset values
	localparam logic [7:0]  RST_COUNT  = 8'h00;
	localparam logic [7:0]  RST_INTCTL = 8'h00;
	localparam logic [7:0]  RST_CONFIG = 8'hFF;
	localparam logic [7:0]  RST_PORT_A_DIRECTION  = 8'hFF;
	localparam logic [15:0] RST_POST   = 16'h0000;

	// interrupt_control field positions
	localparam int BIT_IRQ_ENABLE = 5; // overflow_irq_enable
	localparam int BIT_OVF_FLAG   = 2; // overflow_flag

	// timer_and_pin_config field positions
	localparam int BIT_SRC_SEL  = 5; // count_source_select
	localparam int BIT_EDGE_SEL = 4; // source_edge_select
	localparam int BIT_PS_ASSGN = 3; // prescaler_assignment
	localparam int RATE_MSB     = 2; // prescale_rate_field high bit
	localparam int RATE_LSB     = 0; // prescale_rate_field low bit

	// status / mask field positions
	localparam int BIT_EV_OVF = 0; // count overflow event
	localparam int BIT_EV_WDT = 1; // watchdog postscaler wrap event

	// counter limits
	localparam logic [7:0]  COUNT_MAX   = 8'hFF;
	localparam logic [1:0]  INHIBIT_CYC = 2'h2;
	localparam logic [15:0] POST_MAX    = 16'hFFFF;

	// internal phase clocks, gray order q1 q2 q3 q4
	typedef enum logic [1:0]
	{
		PH_Q1 = 2'b00,
		PH_Q2 = 2'b01,
		PH_Q3 = 2'b11,
		PH_Q4 = 2'b10
	} tmr_phase_t;

endpackage : tmr_pkg

// ---- design/tmr_timer8.sv ----
// 8-bit timer/counter with a prescaler shared with the watchdog, apb register slave
// assumes clk_sys is the oscillator clock, sleep and watchdog inputs come from the same clock
module tmr_timer8
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// apb slave
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// external count pin, asynchronous
	input  wire logic        external_count_pin,
	// core side
	input  wire logic        sleep_mode,
	input  wire logic        watchdog_clear,
	input  wire logic        watchdog_osc_tick,
	output logic             overflow_irq_request,
	output logic             watchdog_wrap,
	output logic             irq
);

	// whole state of the block
	typedef struct packed
	{
		tmr_pkg::tmr_phase_t phase;    // internal phase clock
		logic                pin_s1;   // first sync stage
		logic                pin_s2;   // second sync stage
		logic                pin_s3;   // previous synced level for edge detect
		logic [7:0]          pre;      // shared prescaler count
		logic                pend;     // prescaler output waiting for q2/q4
		logic [7:0]          count;    // count register
		logic [1:0]          inhibit;  // instruction cycles left without increment
		logic [7:0]          intctl;   // interrupt control
		logic [7:0]          config_r; // timer and pin configuration
		logic [7:0]          port_a_direction;    // port a direction, plain storage
		logic [15:0]         post;     // watchdog postscaler
		logic                wrap;     // postscaler wrap pulse
		logic [1:0]          status;   // sticky events
		logic [1:0]          mask;     // event mask
		logic [31:0]         rdata;    // registered read data
	} tmr_state_t;

	// reset image
	localparam tmr_state_t ST_RESET = '{
		phase:    tmr_pkg::PH_Q1,
		pin_s1:   1'b0,
		pin_s2:   1'b0,
		pin_s3:   1'b0,
		pre:      8'h00,
		pend:     1'b0,
		count:    tmr_pkg::RST_COUNT,
		inhibit:  2'h0,
		intctl:   tmr_pkg::RST_INTCTL,
		config_r: tmr_pkg::RST_CONFIG,
		port_a_direction:    tmr_pkg::RST_PORT_A_DIRECTION,
		post:     tmr_pkg::RST_POST,
		wrap:     1'b0,
		status:   2'h0,
		mask:     2'h0,
		rdata:    32'h0000_0000
	};

	tmr_state_t st;      // registered state
	tmr_state_t next_st; // next state

	// decode an apb address into a register index, 0 when unmapped
	function automatic logic [2:0] tmr_decode(input logic [11:0] addr);
		logic [2:0] idx;
		idx = 3'd0;
		if (addr == tmr_pkg::ADDR_COUNT)
			idx = 3'd1;
		else if (addr == tmr_pkg::ADDR_INTCTL)
			idx = 3'd2;
		else if (addr == tmr_pkg::ADDR_CONFIG)
			idx = 3'd3;
		else if (addr == tmr_pkg::ADDR_PORT_A_DIRECTION)
			idx = 3'd4;
		else if (addr == tmr_pkg::ADDR_STATUS)
			idx = 3'd5;
		else if (addr == tmr_pkg::ADDR_MASK)
			idx = 3'd6;
		return idx;
	endfunction : tmr_decode

	// terminal prescaler count for a rate code and owner
	function automatic logic [7:0] tmr_terminal(input logic [2:0] rate, input logic to_wdt);
		logic [3:0] shift;
		logic [8:0] span;
		shift = {1'b0, rate} + {3'b000, ~to_wdt};
		span  = 9'h001 << shift;
		return 8'(span - 9'h001);
	endfunction : tmr_terminal

	// apb handshake: zero wait states, error on unmapped address
	logic       acc_phase; // access phase of any transfer
	logic       wr_en;     // write takes effect this edge
	logic [2:0] sel;       // decoded register index

	always_comb
	begin
		sel       = tmr_decode(paddr);
		acc_phase = psel & penable;
		wr_en     = acc_phase & pwrite & (sel != 3'd0);
	end

	// handshake and data outputs
	assign pready               = acc_phase;
	assign pslverr              = acc_phase & (sel == 3'd0);
	assign prdata               = st.rdata;
	assign watchdog_wrap        = st.wrap;
	assign overflow_irq_request = st.intctl[tmr_pkg::BIT_OVF_FLAG]
		& st.intctl[tmr_pkg::BIT_IRQ_ENABLE];
	assign irq                  = |(st.status & st.mask);

	// next-state logic for the whole block
	always_comb
	begin
		logic       to_wdt;    // prescaler owned by watchdog
		logic       ext_mode;  // counter mode
		logic [2:0] rate;      // prescale rate code
		logic       instr;     // last phase of an instruction cycle
		logic       edge_hit;  // selected edge seen on the pin
		logic       src;       // timer source pulse before prescaler
		logic       pre_in;    // pulse into the shared prescaler
		logic       pre_out;   // prescaler terminal reached
		logic       tmr_tick;  // timer-side pulse after prescaler
		logic       wdt_tick;  // watchdog-side pulse into postscaler
		logic       inc;       // count register advances
		logic       ovf;       // overflow this cycle
		logic       cnt_write; // software writes count register
		logic       sample;    // q2 or q4 sampling point
		to_wdt    = 1'b0;
		ext_mode  = 1'b0;
		rate      = 3'd0;
		instr     = 1'b0;
		edge_hit  = 1'b0;
		src       = 1'b0;
		pre_in    = 1'b0;
		pre_out   = 1'b0;
		tmr_tick  = 1'b0;
		wdt_tick  = 1'b0;
		inc       = 1'b0;
		ovf       = 1'b0;
		cnt_write = 1'b0;
		sample    = 1'b0;
		next_st   = st;

		// configuration decode
		to_wdt   = st.config_r[tmr_pkg::BIT_PS_ASSGN];
		ext_mode = st.config_r[tmr_pkg::BIT_SRC_SEL];
		rate     = st.config_r[tmr_pkg::RATE_MSB:tmr_pkg::RATE_LSB];

		// phase clocks q1..q4, one instruction cycle is four oscillator cycles
		case (st.phase)
			tmr_pkg::PH_Q1: next_st.phase = tmr_pkg::PH_Q2;
			tmr_pkg::PH_Q2: next_st.phase = tmr_pkg::PH_Q3;
			tmr_pkg::PH_Q3: next_st.phase = tmr_pkg::PH_Q4;
			default:        next_st.phase = tmr_pkg::PH_Q1;
		endcase
		instr  = (st.phase == tmr_pkg::PH_Q4);
		sample = (st.phase == tmr_pkg::PH_Q2) | (st.phase == tmr_pkg::PH_Q4);

		// two-stage pin synchroniser, edge taken from the second stage onward
		next_st.pin_s1 = external_count_pin;
		next_st.pin_s2 = st.pin_s1;
		next_st.pin_s3 = st.pin_s2;
		if (st.config_r[tmr_pkg::BIT_EDGE_SEL])
			edge_hit = st.pin_s3 & ~st.pin_s2;
		else
			edge_hit = ~st.pin_s3 & st.pin_s2;

		// timer source: pin edges or instruction cycles, frozen during sleep
		if (ext_mode)
			src = edge_hit & ~sleep_mode;
		else
			src = instr & ~sleep_mode;

		// shared prescaler, fed by exactly one owner
		pre_in  = to_wdt ? watchdog_osc_tick : src;
		pre_out = pre_in & (st.pre == tmr_terminal(rate, to_wdt));
		if (pre_in)
		begin
			// wrap to zero at the terminal count
			next_st.pre = pre_out ? 8'h00 : 8'(st.pre + 8'h01);
		end

		// timer and watchdog pulses after the prescaler stage
		tmr_tick = to_wdt ? src : pre_out;
		wdt_tick = to_wdt ? pre_out : watchdog_osc_tick;

		// counter mode waits for q2/q4, timer mode advances directly
		if (ext_mode)
		begin
			if (tmr_tick)
				next_st.pend = 1'b1;
			if (sample & (st.pend | tmr_tick))
			begin
				inc          = ~sleep_mode;
				next_st.pend = 1'b0;
			end
		end
		else
		begin
			inc          = tmr_tick;
			next_st.pend = 1'b0;
		end

		// increments are held off after a count write
		if (st.inhibit != 2'h0)
			inc = 1'b0;
		if (instr & (st.inhibit != 2'h0))
			next_st.inhibit = 2'(st.inhibit - 2'h1);

		// count register and overflow
		if (inc)
		begin
			next_st.count = 8'(st.count + 8'h01);
			ovf           = (st.count == tmr_pkg::COUNT_MAX);
		end

		// watchdog postscaler, fed through the prescaler when the assignment bit gives it to the watchdog
		next_st.wrap = 1'b0;
		if (wdt_tick)
		begin
			next_st.post = 16'(st.post + 16'h0001);
			next_st.wrap = (st.post == tmr_pkg::POST_MAX);
		end

		// watchdog clear restarts the postscaler and an owned prescaler
		if (watchdog_clear)
		begin
			next_st.post = tmr_pkg::RST_POST;
			next_st.wrap = 1'b0;
			if (to_wdt)
				next_st.pre = 8'h00;
		end

		// register writes at the access edge
		if (wr_en)
		begin
			if (sel == 3'd1)
			begin
				// write beats a same-cycle increment
				cnt_write       = 1'b1;
				next_st.count   = pwdata[7:0];
				next_st.inhibit = tmr_pkg::INHIBIT_CYC;
				next_st.pend    = 1'b0;
				if (!to_wdt)
					next_st.pre = 8'h00;
			end
			else if (sel == 3'd2)
				next_st.intctl = pwdata[7:0];
			else if (sel == 3'd3)
				next_st.config_r = pwdata[7:0];
			else if (sel == 3'd4)
				next_st.port_a_direction = pwdata[7:0];
			else if (sel == 3'd5)
				next_st.status = st.status & ~pwdata[1:0];
			else if (sel == 3'd6)
				next_st.mask = pwdata[1:0];
		end
		if (cnt_write)
			ovf = 1'b0;

		// overflow sets the flag whatever the enable, set wins over clear
		if (ovf)
		begin
			next_st.intctl[tmr_pkg::BIT_OVF_FLAG] = 1'b1;
			next_st.status[tmr_pkg::BIT_EV_OVF]   = 1'b1;
		end
		if (next_st.wrap)
			next_st.status[tmr_pkg::BIT_EV_WDT] = 1'b1;

		// read data captured in the setup cycle
		if (psel & ~penable & ~pwrite)
		begin
			next_st.rdata = 32'h0000_0000;
			if (sel == 3'd1)
				next_st.rdata[7:0] = st.count;
			else if (sel == 3'd2)
				next_st.rdata[7:0] = st.intctl;
			else if (sel == 3'd3)
				next_st.rdata[7:0] = st.config_r;
			else if (sel == 3'd4)
				next_st.rdata[7:0] = st.port_a_direction;
			else if (sel == 3'd5)
				next_st.rdata[1:0] = st.status;
			else if (sel == 3'd6)
				next_st.rdata[1:0] = st.mask;
		end
	end

	// state register, synchronous active-low reset
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			st <= ST_RESET;
		else
			st <= next_st;
	end

endmodule : tmr_timer8

// ---- testbench/tmr_ext_src.sv ----
// far side of the timer: external count source and watchdog time base
// assumes the bench steers it, one clock domain with the timer
module tmr_ext_src
(
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// bench commands
	input  wire logic pin_level,
	input  wire logic tick_en,
	// toward the timer
	output logic      external_count_pin,
	output logic      watchdog_osc_tick
);
	timeunit 1ns;
	timeprecision 1ns;

	// pin follows its command one cycle late, ticks run every cycle when on
	always_ff @(posedge clk_sys)
	begin
		external_count_pin <= pin_level;
		watchdog_osc_tick  <= rst_n && tick_en;
	end
endmodule : tmr_ext_src

// ---- testbench/tmr_timer8_properties.sv ----
// port checker for the 8-bit timer, bound into every tmr_timer8
// assumes zero-wait apb and registered interrupt outputs
module tmr_timer8_chk
(
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        rst_n,
	// apb
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// core side
	input wire logic        sleep_mode,
	input wire logic        overflow_irq_request,
	input wire logic        watchdog_wrap,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// write to interrupt_control taking effect at this edge
	wire logic wr_ctl = psel && penable && pwrite && paddr == tmr_pkg::ADDR_INTCTL;

	// write to the count register taking effect
	sequence s_wr_cnt;
		psel && penable && pwrite && paddr == tmr_pkg::ADDR_COUNT;
	endsequence
	// core asleep for three edges
	sequence s_asleep;
		sleep_mode [*3];
	endsequence

	AST_ZERO_WAIT: assert property (pready == (psel && penable))
		else $error("pready not zero wait");
	AST_UNMAPPED: assert property (psel && penable && paddr > 12'h014 |-> pslverr)
		else $error("no error on unmapped address");
	AST_RD_UPPER: assert property (psel && !penable && !pwrite |=> prdata[31:8] == '0)
		else $error("read data upper bits set");
	AST_RESET_QUIET: assert property ($rose(rst_n) |-> !irq && !overflow_irq_request)
		else $error("interrupt active after reset");
	AST_FLAG_HOLD: assert property (overflow_irq_request && !wr_ctl |=> overflow_irq_request)
		else $error("overflow request dropped by itself");
	AST_ENABLE_GATE: assert property (wr_ctl && !pwdata[tmr_pkg::BIT_IRQ_ENABLE] |=> !overflow_irq_request)
		else $error("request with enable clear");
	AST_SLEEP_FROZEN: assert property (s_asleep ##0 (!overflow_irq_request && !wr_ctl)
		|=> !overflow_irq_request)
		else $error("overflow during sleep");
	AST_WRAP_PULSE: assert property (watchdog_wrap |=> !watchdog_wrap)
		else $error("watchdog wrap longer than one cycle");
	AST_WRITE_INHIBIT: assert property (s_wr_cnt ##0 !overflow_irq_request
		|=> !overflow_irq_request [*5])
		else $error("count advanced right after write");
endmodule : tmr_timer8_chk

bind tmr_timer8 tmr_timer8_chk tmr_timer8_chk_i (.*);

// ---- testbench/tb_top.sv ----
// self-checking bench for the 8-bit timer over apb
// assumes zero-wait apb and one instruction tick every fourth clock
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, se;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, a;
	logic        pin_level, tick_en, external_count_pin, watchdog_osc_tick;
	logic        sleep_mode, watchdog_clear, overflow_irq_request, watchdog_wrap, irq;
	logic [7:0]  rv [6] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00}; // reset table
	logic [7:0]  cfg [4] = '{8'h08, 8'h00, 8'h01, 8'h02}; // direct, 1:2, 1:4, 1:8
	int          per [4] = '{4, 8, 16, 32}; // clocks per count
	int          err_count, tests_run, c;

	tmr_timer8 tmr_timer8_i (.clk_sys, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
		.pready, .prdata, .pslverr, .external_count_pin, .sleep_mode, .watchdog_clear,
		.watchdog_osc_tick, .overflow_irq_request, .watchdog_wrap, .irq);
	tmr_ext_src tmr_ext_src_i (.clk_sys, .rst_n, .pin_level, .tick_en, .external_count_pin,
		.watchdog_osc_tick);

	// verdict and end of run
	task automatic end_of_test();
		if (err_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test

	// compare and count
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// one apb transfer, held until pready, then one idle edge
	task automatic bus(input logic [11:0] ad, input logic wr, input logic [31:0] wd);
		int n;
		paddr   <= ad;
		pwrite  <= wr;
		pwdata  <= wd;
		psel    <= 1'b1;
		@(posedge clk_sys);
		penable <= 1'b1;
		for (n = 0; n < 16; n++)
		begin
			@(posedge clk_sys);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		se = pslverr;
		if (n == 16)
		begin
			err_count++;
			end_of_test();
		end
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : bus

	// one-cycle watchdog clear pulse
	task automatic wd_clear();
		watchdog_clear <= 1'b1;
		@(posedge clk_sys);
		watchdog_clear <= 1'b0;
	endtask : wd_clear

	// clock generator
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// main sequence
	initial
	begin
		{rst_n, psel, penable, pwrite, pin_level, tick_en, sleep_mode, watchdog_clear} = '0;
		paddr  = '0;
		pwdata = '0;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		// reset values, then an unmapped word
		foreach (rv[i])
		begin
			bus(12'(4 * i), 1'b0, '0);
			check("reset value", rd, {24'h0, rv[i]});
		end
		bus(12'h018, 1'b0, '0);
		check("unmapped error", se, 1);
		check("unmapped data", rd, 0);
		// wrap with the request disabled
		bus(12'h008, 1'b1, 32'h08);
		bus(12'h000, 1'b1, 32'hFF);
		repeat (16) @(posedge clk_sys);
		bus(12'h004, 1'b0, '0);
		check("flag set", rd, 32'h04);
		check("request off", overflow_irq_request, 0);
		bus(12'h014, 1'b1, 32'h01);
		check("irq raised", irq, 1);
		bus(12'h010, 1'b1, 32'h01);
		check("irq cleared", irq, 0);
		bus(12'h014, 1'b1, 32'h00);
		bus(12'h004, 1'b1, 32'h24);
		check("request on", overflow_irq_request, 1);
		bus(12'h004, 1'b1, 32'h20);
		check("request cleared", overflow_irq_request, 0);
		// first count after a write waits two instruction cycles
		bus(12'h000, 1'b1, 32'hFF);
		for (c = 1; c < 40 && overflow_irq_request !== 1'b1; c++)
			@(posedge clk_sys);
		if (c >= 40)
		begin
			err_count++;
			end_of_test();
		end
		check("inhibit window", c >= 10 && c <= 14, 1);
		bus(12'h004, 1'b1, 32'h00);
		// frozen while asleep
		sleep_mode <= 1'b1;
		bus(12'h000, 1'b0, '0);
		a = rd;
		repeat (40) @(posedge clk_sys);
		bus(12'h000, 1'b0, '0);
		check("frozen", rd, a);
		sleep_mode <= 1'b0;
		// direct, 1:2, 1:4 and 1:8 each counted over three periods at equal phase
		foreach (cfg[i])
		begin
			wd_clear();
			bus(12'h008, 1'b1, {24'h0, cfg[i]});
			bus(12'h000, 1'b0, '0);
			a = rd;
			// the two read setup edges lie exactly three periods apart
			repeat (per[i] * 3 - 3) @(posedge clk_sys);
			bus(12'h000, 1'b0, '0);
			check("rate", {24'h0, rd[7:0] - a[7:0]}, 3);
		end
		// pin counting on each edge sense
		for (int e = 0; e < 2; e++)
		begin
			pin_level <= e[0];
			repeat (12) @(posedge clk_sys);
			wd_clear();
			bus(12'h000, 1'b1, '0);
			bus(12'h008, 1'b1, {26'h0, 1'b1, e[0], 4'h8});
			wd_clear();
			for (int k = 0; k < 3; k++)
			begin
				pin_level <= e[0] ^ (k == 1);
				repeat (12) @(posedge clk_sys);
				bus(12'h000, 1'b0, '0);
				check("pin count", rd, 32'(k != 0));
			end
		end
		// postscaler restarts on clear and wraps after 65536 ticks through the watchdog-owned prescaler at 1:1
		bus(12'h014, 1'b1, 32'h02);
		tick_en <= 1'b1;
		repeat (1000) @(posedge clk_sys);
		wd_clear();
		for (c = 0; c < 70000 && watchdog_wrap !== 1'b1; c++)
			@(posedge clk_sys);
		if (c >= 70000)
		begin
			err_count++;
			end_of_test();
		end
		check("wrap time", c >= 65530 && c <= 65542, 1);
		repeat (2) @(posedge clk_sys);
		check("wrap irq", irq, 1);
		end_of_test();
	end
endmodule : tb_top
